//--- bench/edic_checker.sv
// Purpose: Port assertions for the discrete input control block.
// Assumes: One clock domain, synchronous reset.
// Notes:   Windows allow for the input synchroniser.
`timescale 1ns/1ns
`default_nettype none
module edic_checker (
	input wire logic core_clk,       // Clock
	input wire logic rst,            // Reset
	input wire logic din_trip,       // Trip pin
	input wire logic din_fb_closed,  // Breaker contact
	input wire logic din_bus_en,     // Bus enable pin
	input wire logic trip_latched,   // Latched trip
	input wire logic exc_on,         // Excitation
	input wire logic phase_retard,   // Retard
	input wire logic fb_open_order,  // Open order
	input wire logic fb_close_order, // Close order
	input wire logic fb_is_closed,   // Feedback
	input wire logic remote_active   // Remote status
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	chk_trip_latch: assert property ($rose(din_trip) |-> ##[1:6] trip_latched)
		else $error("trip not latched");
	chk_trip_exc_off: assert property ($rose(trip_latched) |-> ##[0:1] !exc_on)
		else $error("excitation kept on");
	chk_retard_start: assert property ($rose(trip_latched) |-> ##[0:2] phase_retard)
		else $error("no retard");
	chk_retard_hold: assert property ($rose(phase_retard) |-> phase_retard [*8])
		else $error("retard too short");
	chk_open_after: assert property ($fell(phase_retard) |-> ##[0:1] fb_open_order)
		else $error("no open after retard");
	chk_close_block: assert property (trip_latched |-> !$rose(fb_close_order))
		else $error("close during trip");
	chk_fb_follow: assert property (($stable(din_fb_closed)) [*5] |-> fb_is_closed == din_fb_closed)
		else $error("feedback wrong");
	chk_remote_off: assert property ((!din_bus_en) [*5] |-> !remote_active)
		else $error("remote without enable");
	cover property ($rose(phase_retard));
	cover property ($rose(remote_active));
	cover property ($fell(fb_is_closed));
endmodule : edic_checker
bind edic_top edic_checker edic_checker_inst (.*);
`default_nettype wire

//--- bench/edic_plant.sv
// Purpose: Field breaker with an auxiliary closed contact.
// Assumes: Orders are levels held until the contact moves.
// Notes:   LAG sets the travel time, slow or prompt.
`timescale 1ns/1ns
`default_nettype none
module edic_plant #(
	parameter int unsigned LAG = 3 // Travel cycles
) (
	input  wire logic core_clk,  // Clock
	input  wire logic open_ord,  // Open order
	input  wire logic close_ord, // Close order
	output var logic  fb_closed  // Closed contact
);
	int unsigned cnt = 0;
	initial fb_closed = 1'b0;
	// Contact moves only after the full travel time
	always @(posedge core_clk) begin
		if (fb_closed ? open_ord : close_ord) begin
			cnt <= cnt + 1;
			if (cnt == LAG)
				fb_closed <= !fb_closed;
		end else
			cnt <= 0;
	end
endmodule : edic_plant
`default_nettype wire

//--- bench/test_excitation_discrete_input_control.sv
// Purpose: Self-checking bench for the discrete input control block.
// Assumes: 1 ms shortened to 10 clocks.
// Notes:   Pins change at rising edges, outputs compared at falling edges.
`timescale 1ns/1ns
`default_nettype none
module test_excitation_discrete_input_control;
	logic        core_clk, rst, reg_wr, reg_rd, fb_closed;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [17:0] pin;
	logic [1:0]  mode;
	logic        exc_on, trip_latched, phase_retard, fb_open_order, fb_close_order, fb_is_closed, remote_active;
	logic        unloading;
	logic [15:0] active_ref, test_ref;
	int          n_fail = 0;
	int          checks = 0;
	edic_top #(.MS_CYCLES(10)) edic_top_inst (.*,
		.din_raise(pin[0]), .din_lower(pin[1]), .din_test_raise(pin[2]), .din_test_lower(pin[3]),
		.din_cmd_vreg(pin[4]), .din_cmd_fcur(pin[5]), .din_cmd_qpow(pin[6]), .din_cmd_pfac(pin[7]),
		.din_bus_en(pin[8]), .din_override(pin[9]), .din_unload(pin[10]), .din_trip_reset(pin[11]),
		.din_fb_closed(fb_closed), .din_exc_off(pin[13]), .din_exc_on(pin[14]), .din_fb_open(pin[15]),
		.din_fb_close(pin[16]), .din_trip(pin[17]));
	edic_plant #(.LAG(8)) edic_plant_inst (.core_clk(core_clk), .open_ord(fb_open_order),
		.close_ord(fb_close_order), .fb_closed(fb_closed));
	////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done
	task automatic ck(logic ok);
		checks++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("unexpected at %0t: check %0d mismatch", $time, checks);
		end
	endtask : ck
	task automatic w(int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask : w
	task automatic set(int i, logic v, int n);
		@(posedge core_clk);
		pin[i] <= v;
		w(n);
	endtask : set
	task automatic pl(int i, int n);
		set(i, 1'b1, n);
		set(i, 1'b0, 4);
	endtask : pl
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(logic [7:0] a, logic [31:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		ck(reg_rdata === e);
	endtask : rd
	////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = !core_clk;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		test_done();
	end
	initial begin
		rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		pin = '0;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h64);
		rd(8'h08, 32'h2710);
		rd(8'h18, 32'h8000);
		rd(8'h20, 32'h0);
		$display("test reset done");
		pl(5, 10);
		ck(mode === 2'h0);
		wr(8'h00, 32'h1);
		for (int i = 1; i < 5; i++) begin
			pl(4 + i % 4, 10);
			ck(mode === 2'(i % 4));
		end
		wr(8'h0C, 32'h0);
		pl(0, 60);
		ck(active_ref > 16'h8000);
		pl(1, 120);
		ck(active_ref < 16'h8000);
		pl(2, 60);
		ck(test_ref === 16'h8000);
		wr(8'h00, 32'h3);
		pl(2, 60);
		ck(test_ref > 16'h8000);
		$display("test modes and reference done");
		pl(14, 10);
		ck(exc_on === 1'b1);
		pl(13, 10);
		ck(exc_on === 1'b0);
		pl(16, 20);
		ck(fb_is_closed === 1'b1);
		pl(15, 2);
		ck(fb_open_order === 1'b1);
		w(20);
		ck(fb_is_closed === 1'b0 && fb_open_order === 1'b0);
		pl(16, 20);
		pl(14, 10);
		wr(8'h04, 32'h3);
		pl(17, 6);
		ck(phase_retard === 1'b1 && fb_is_closed === 1'b1 && exc_on === 1'b0);
		pl(16, 10);
		ck(fb_close_order === 1'b0);
		w(60);
		ck(phase_retard === 1'b0 && fb_is_closed === 1'b0 && trip_latched === 1'b1);
		pl(11, 10);
		ck(trip_latched === 1'b0);
		$display("test breaker and trip done");
		wr(8'h08, 32'h3);
		pl(10, 4);
		ck(unloading === 1'b1);
		w(50);
		ck(unloading === 1'b0);
		wr(8'h00, 32'h8);
		set(9, 1'b1, 4);
		pl(6, 10);
		ck(mode === 2'h2);
		set(8, 1'b1, 6);
		ck(remote_active === 1'b0);
		wr(8'h00, 32'h18);
		w(6);
		ck(remote_active === 1'b1);
		wr(8'h10, 32'h0D);
		w(0);
		ck(mode === 2'h2);
		set(9, 1'b0, 4);
		wr(8'h10, 32'h0D);
		w(0);
		ck(mode === 2'h1);
		wr(8'h10, 32'h07);
		w(0);
		ck(mode === 2'h3);
		set(8, 1'b0, 8);
		ck(remote_active === 1'b0);
		wr(8'h10, 32'h0C);
		w(0);
		ck(mode === 2'h3);
		$display("test unload, override and bus done");
		test_done();
	end
endmodule : test_excitation_discrete_input_control
`default_nettype wire

//--- verilog/edic_consts.svh
// Purpose: Constants of the excitation discrete input control block.
// Assumes: Included by bare name from the synchroniser and top design files.
// Notes:   Register offsets are byte addresses, one 32-bit word each.
`ifndef EDIC_CONSTS_SVH
`define EDIC_CONSTS_SVH

// Timing
`define EDIC_CLK_NS        40
`define EDIC_MS_NS         1000000
`define EDIC_SYNC_STAGES   2

// Widths
`define EDIC_ADDR_W        8
`define EDIC_DATA_W        32
`define EDIC_REF_W         16
`define EDIC_MS_W          16

// Register byte addresses
`define EDIC_A_CTRL        8'h00
`define EDIC_A_STOP_DLY    8'h04
`define EDIC_A_UNLOAD_TO   8'h08
`define EDIC_A_RAMP        8'h0C
`define EDIC_A_CMD         8'h10
`define EDIC_A_STATUS      8'h14
`define EDIC_A_ACT_REF     8'h18
`define EDIC_A_TEST_REF    8'h1C

// Control register fields
`define EDIC_F_SRC         0
`define EDIC_F_FORCE_LO    1
`define EDIC_F_FORCE_HI    2
`define EDIC_F_REQ_PERM    3
`define EDIC_F_PERMIT      4
`define EDIC_CTRL_W        5
`define EDIC_CTRL_RST      5'h00
`define EDIC_SRC_PANEL     1'b0
`define EDIC_SRC_DI        1'b1
`define EDIC_FORCE_NONE    2'h0
`define EDIC_FORCE_VALUE   2'h1
`define EDIC_FORCE_OPEN    2'h2

// Timing register reset values, in milliseconds
`define EDIC_STOP_DLY_RST  16'h0064
`define EDIC_UNLOAD_TO_RST 16'h2710
`define EDIC_RAMP_RST      16'h000A

// Command register fields
`define EDIC_F_CMD_MODE_LO 0
`define EDIC_F_CMD_MODE_HI 1
`define EDIC_F_CMD_VALID   2
`define EDIC_F_CMD_BUS     3

// Status register fields
`define EDIC_F_ST_MODE_LO  0
`define EDIC_F_ST_MODE_HI  1
`define EDIC_F_ST_EXC      2
`define EDIC_F_ST_TRIP     3
`define EDIC_F_ST_REMOTE   4
`define EDIC_F_ST_RETARD   5
`define EDIC_F_ST_FB_OPEN  6
`define EDIC_F_ST_FB_CLOSE 7
`define EDIC_F_ST_UNLOAD   8
`define EDIC_F_ST_FB_IN    9
`define EDIC_F_ST_OVR      10

// Discrete input pin indices
`define EDIC_P_RAISE       0
`define EDIC_P_LOWER       1
`define EDIC_P_T_RAISE     2
`define EDIC_P_T_LOWER     3
`define EDIC_P_VREG        4
`define EDIC_P_FCUR        5
`define EDIC_P_QPOW        6
`define EDIC_P_PFAC        7
`define EDIC_P_BUS_EN      8
`define EDIC_P_OVR         9
`define EDIC_P_UNLOAD      10
`define EDIC_P_TRIP_RST    11
`define EDIC_P_FB_CLOSED   12
`define EDIC_P_EXC_OFF     13
`define EDIC_P_EXC_ON      14
`define EDIC_P_FB_OPEN     15
`define EDIC_P_FB_CLOSE    16
`define EDIC_P_TRIP        17
`define EDIC_NPINS         18

`endif

//--- verilog/edic_pkg.sv
// Purpose: Types of the excitation discrete input control block.
// Assumes: Used by scoped name only.
// Notes:   Mode order matches the two-bit mode field of the status word.
package edic_pkg;
	typedef enum logic [1:0] {
		VOLTAGE_REGULATION_MODE,
		FIELD_CURRENT_MODE,
		REACTIVE_POWER_MODE,
		POWER_FACTOR_MODE
	} edic_mode_t;

	typedef enum logic [1:0] {
		TRIP_IDLE,
		TRIP_RETARD,
		TRIP_OPEN
	} edic_trip_st_t;
endpackage : edic_pkg

//--- verilog/edic_sync.sv
// Purpose: Two-flop synchroniser and rising edge detector per input.
// Assumes: Inputs are asynchronous plant contacts.
// Notes:   Only the second stage feeds the edge detector.
`timescale 1ns/1ns
`default_nettype none
`include "edic_consts.svh"
module edic_sync #(
	parameter int unsigned N = 1 // Number of inputs
) (
	input  wire logic         core_clk, // System clock
	input  wire logic         rst,      // Synchronous reset, active high
	input  wire logic [N-1:0] pins,     // Raw plant inputs
	edic_sync_if.src          so        // Synchronised levels and edges
);
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_bit
			logic [`EDIC_SYNC_STAGES-1:0] meta_ff;
			logic                         last_ff;
			always_ff @(posedge core_clk) begin
				if (rst) begin
					meta_ff <= '0;
					last_ff <= 1'b0;
				end else begin
					meta_ff <= {meta_ff[0], pins[i]};
					last_ff <= meta_ff[1];
				end
			end
			assign so.lvl[i]  = meta_ff[1];
			assign so.rise[i] = meta_ff[1] & ~last_ff;
		end
	endgenerate
endmodule : edic_sync
`default_nettype wire

//--- verilog/edic_sync_if.sv
// Purpose: Carries synchronised input levels and their rising edges.
// Assumes: Single clock domain on both sides.
// Notes:   Rise is a one-cycle pulse aligned with the level going high.
`timescale 1ns/1ns
`default_nettype none
interface edic_sync_if #(
	parameter int unsigned N = 1 // Number of inputs
);
	logic [N-1:0] lvl;
	logic [N-1:0] rise;
	modport src (output lvl, output rise);
	modport dst (input lvl, input rise);
endinterface : edic_sync_if
`default_nettype wire

//--- verilog/edic_top.sv
// Purpose: Interprets the discrete control inputs of an excitation controller.
// Assumes: 25 MHz core_clk, synchronous active-high rst, plain register port.
// Notes:   Timings are kept in milliseconds and counted on a shared tick.
//
// How it works
// - While raise is held, the selected regulator reference steps up.
// - While lower is held, the selected regulator reference steps down.
// - Test raise and lower work only under forced value or open loop option.
// - Test, mode, unload and breaker command inputs are read only under discrete input control.
// - Voltage mode command selects terminal voltage regulation.
// - Field current mode command selects field current regulation.
// - Reactive power mode command selects reactive power regulation.
// - Power factor mode command selects power factor regulation.
// - Bus enable input activates bus commands, optionally gated by a permission setting.
// - Local override gives discrete inputs priority over panel and bus commands.
// - Trip reset input clears the latched trip.
// - Breaker closed input is the field breaker position feedback.
// - Excitation off command switches excitation off.
// - Excitation on command switches excitation on.
// - Breaker open command issues an open order.
// - Breaker close command issues a close order.
// - Trip input retards phase for the stopping delay, then opens the breaker.
// - Remote active status follows bus enable and the permission setting; local override does not clear it.
// - A dedicated output carries the field breaker open order.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "edic_consts.svh"
module edic_top #(
	parameter int unsigned MS_CYCLES = `EDIC_MS_NS / `EDIC_CLK_NS, // Clock cycles per millisecond
	parameter int unsigned REF_W     = `EDIC_REF_W                  // Reference value width
) (
	input  wire logic                    core_clk,       // System clock
	input  wire logic                    rst,            // Synchronous reset, active high
	input  wire logic [`EDIC_ADDR_W-1:0] reg_addr,       // Register byte address
	input  wire logic [`EDIC_DATA_W-1:0] reg_wdata,      // Register write data
	input  wire logic                    reg_wr,         // Write strobe
	input  wire logic                    reg_rd,         // Read strobe
	output logic      [`EDIC_DATA_W-1:0] reg_rdata,      // Read data, cycle after strobe
	input  wire logic                    din_raise,      // Raise reference
	input  wire logic                    din_lower,      // Lower reference
	input  wire logic                    din_test_raise, // Test-mode raise
	input  wire logic                    din_test_lower, // Test-mode lower
	input  wire logic                    din_cmd_vreg,   // Voltage regulation mode command
	input  wire logic                    din_cmd_fcur,   // Field current mode command
	input  wire logic                    din_cmd_qpow,   // Reactive power mode command
	input  wire logic                    din_cmd_pfac,   // Power factor mode command
	input  wire logic                    din_bus_en,     // Remote bus activation
	input  wire logic                    din_override,   // Local override
	input  wire logic                    din_unload,     // Reactive unload request
	input  wire logic                    din_trip_reset, // Trip reset
	input  wire logic                    din_fb_closed,  // Field breaker closed feedback
	input  wire logic                    din_exc_off,    // Excitation off command
	input  wire logic                    din_exc_on,     // Excitation on command
	input  wire logic                    din_fb_open,    // Field breaker open command
	input  wire logic                    din_fb_close,   // Field breaker close command
	input  wire logic                    din_trip,       // Incoming trip
	output logic      [1:0]              mode,           // Active regulator mode
	output logic                         exc_on,         // Excitation running
	output logic                         trip_latched,   // Latched trip
	output logic                         phase_retard,   // Converter held in phase retard
	output logic                         fb_open_order,  // Field breaker open order
	output logic                         fb_close_order, // Field breaker close order
	output logic                         fb_is_closed,   // Breaker position feedback
	output logic                         remote_active,  // Remote bus control active
	output logic                         unloading,      // Reactive unloading running
	output logic      [REF_W-1:0]        active_ref,     // Reference of active mode
	output logic      [REF_W-1:0]        test_ref        // Test-mode reference
);
	////////////////////////////////////////////////////////////////////////////
	// Input synchronisation
	logic [`EDIC_NPINS-1:0] pins;
	edic_sync_if #(.N(`EDIC_NPINS)) sif ();

	assign pins = {din_trip, din_fb_close, din_fb_open, din_exc_on, din_exc_off,
		din_fb_closed, din_trip_reset, din_unload, din_override, din_bus_en,
		din_cmd_pfac, din_cmd_qpow, din_cmd_fcur, din_cmd_vreg,
		din_test_lower, din_test_raise, din_lower, din_raise};

	edic_sync #(.N(`EDIC_NPINS)) edic_sync_inst (
		.core_clk (core_clk),
		.rst      (rst),
		.pins     (pins),
		.so       (sif.src)
	);

	////////////////////////////////////////////////////////////////////////////
	// Settings registers
	logic [`EDIC_CTRL_W-1:0] ctrl_ff;
	logic [`EDIC_MS_W-1:0]   stop_dly_ff;
	logic [`EDIC_MS_W-1:0]   unload_to_ff;
	logic [`EDIC_MS_W-1:0]   ramp_ff;
	logic                    wr_cmd;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_ff      <= `EDIC_CTRL_RST;
			stop_dly_ff  <= `EDIC_STOP_DLY_RST;
			unload_to_ff <= `EDIC_UNLOAD_TO_RST;
			ramp_ff      <= `EDIC_RAMP_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				`EDIC_A_CTRL:      ctrl_ff      <= reg_wdata[`EDIC_CTRL_W-1:0];
				`EDIC_A_STOP_DLY:  stop_dly_ff  <= reg_wdata[`EDIC_MS_W-1:0];
				`EDIC_A_UNLOAD_TO: unload_to_ff <= reg_wdata[`EDIC_MS_W-1:0];
				`EDIC_A_RAMP:      ramp_ff      <= reg_wdata[`EDIC_MS_W-1:0];
				default: begin
				end
			endcase
		end
	end

	assign wr_cmd = reg_wr && (reg_addr == `EDIC_A_CMD) && reg_wdata[`EDIC_F_CMD_VALID];

	////////////////////////////////////////////////////////////////////////////
	// Command sources
	logic di_ok;
	logic panel_ok;
	logic bus_ok;
	logic sw_ok;
	logic forced_ok;
	logic [1:0] force_sel;

	assign force_sel = ctrl_ff[`EDIC_F_FORCE_HI:`EDIC_F_FORCE_LO];
	assign di_ok    = (ctrl_ff[`EDIC_F_SRC] == `EDIC_SRC_DI) || sif.lvl[`EDIC_P_OVR];
	assign panel_ok = (ctrl_ff[`EDIC_F_SRC] == `EDIC_SRC_PANEL) && !sif.lvl[`EDIC_P_OVR];
	assign bus_ok   = remote_active && !sif.lvl[`EDIC_P_OVR];
	assign sw_ok    = wr_cmd && (reg_wdata[`EDIC_F_CMD_BUS] ? bus_ok : panel_ok);
	assign forced_ok = di_ok && ((force_sel == `EDIC_FORCE_VALUE) || (force_sel == `EDIC_FORCE_OPEN));

	always_ff @(posedge core_clk) begin
		if (rst) begin
			remote_active <= 1'b0;
		end else begin
			remote_active <= sif.lvl[`EDIC_P_BUS_EN] &&
				(!ctrl_ff[`EDIC_F_REQ_PERM] || ctrl_ff[`EDIC_F_PERMIT]);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Millisecond tick and reference ramp pace
	logic [31:0]           ms_cnt_ff;
	logic                  ms_tick;
	logic [`EDIC_MS_W-1:0] ramp_cnt_ff;
	logic                  step;

	assign ms_tick = (ms_cnt_ff == 32'(MS_CYCLES - 1));

	always_ff @(posedge core_clk) begin
		if (rst || ms_tick) begin
			ms_cnt_ff <= '0;
		end else begin
			ms_cnt_ff <= ms_cnt_ff + 32'h1;
		end
	end

	// Reference moves one count per ramp period so a held input slews, not jumps
	assign step = ms_tick && (ramp_cnt_ff >= ramp_ff);

	always_ff @(posedge core_clk) begin
		if (rst || step) begin
			ramp_cnt_ff <= '0;
		end else if (ms_tick) begin
			ramp_cnt_ff <= ramp_cnt_ff + `EDIC_MS_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Regulator mode
	edic_pkg::edic_mode_t mode_ff;
	edic_pkg::edic_mode_t nxt_mode;

	always_comb begin
		nxt_mode = mode_ff;
		if (sw_ok) begin
			nxt_mode = edic_pkg::edic_mode_t'(reg_wdata[`EDIC_F_CMD_MODE_HI:`EDIC_F_CMD_MODE_LO]);
		end
		if (di_ok) begin
			if (sif.rise[`EDIC_P_VREG]) begin
				nxt_mode = edic_pkg::VOLTAGE_REGULATION_MODE;
			end else if (sif.rise[`EDIC_P_FCUR]) begin
				nxt_mode = edic_pkg::FIELD_CURRENT_MODE;
			end else if (sif.rise[`EDIC_P_QPOW]) begin
				nxt_mode = edic_pkg::REACTIVE_POWER_MODE;
			end else if (sif.rise[`EDIC_P_PFAC]) begin
				nxt_mode = edic_pkg::POWER_FACTOR_MODE;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode_ff <= edic_pkg::VOLTAGE_REGULATION_MODE;
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	assign mode = mode_ff;

	////////////////////////////////////////////////////////////////////////////
	// Reference values, one per regulator mode
	logic [REF_W-1:0] ref_ff [4];
	logic [REF_W-1:0] ref_mid;
	logic             up;
	logic             dn;
	logic             t_up;
	logic             t_dn;

	assign ref_mid = {1'b1, {(REF_W-1){1'b0}}};
	assign up   = sif.lvl[`EDIC_P_RAISE] && !sif.lvl[`EDIC_P_LOWER];
	assign dn   = sif.lvl[`EDIC_P_LOWER] && !sif.lvl[`EDIC_P_RAISE];
	assign t_up = forced_ok && sif.lvl[`EDIC_P_T_RAISE] && !sif.lvl[`EDIC_P_T_LOWER];
	assign t_dn = forced_ok && sif.lvl[`EDIC_P_T_LOWER] && !sif.lvl[`EDIC_P_T_RAISE];

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_ref
			always_ff @(posedge core_clk) begin
				if (rst) begin
					ref_ff[gi] <= ref_mid;
				end else if (step && (mode_ff == edic_pkg::edic_mode_t'(gi))) begin
					if (up && (ref_ff[gi] != {REF_W{1'b1}})) begin
						ref_ff[gi] <= ref_ff[gi] + REF_W'(1);
					end else if (dn && (ref_ff[gi] != {REF_W{1'b0}})) begin
						ref_ff[gi] <= ref_ff[gi] - REF_W'(1);
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (rst) begin
			active_ref <= ref_mid;
		end else begin
			active_ref <= ref_ff[mode_ff];
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			test_ref <= ref_mid;
		end else if (step) begin
			if (t_up && (test_ref != {REF_W{1'b1}})) begin
				test_ref <= test_ref + REF_W'(1);
			end else if (t_dn && (test_ref != {REF_W{1'b0}})) begin
				test_ref <= test_ref - REF_W'(1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Trip latch and excitation
	// set wins over reset
	always_ff @(posedge core_clk) begin
		if (rst) begin
			trip_latched <= 1'b0;
		end else if (sif.rise[`EDIC_P_TRIP]) begin
			trip_latched <= 1'b1;
		end else if (sif.rise[`EDIC_P_TRIP_RST]) begin
			trip_latched <= 1'b0;
		end
	end

	// Off wins over on, and a latched trip keeps excitation from restarting
	always_ff @(posedge core_clk) begin
		if (rst) begin
			exc_on <= 1'b0;
		end else if (sif.rise[`EDIC_P_EXC_OFF] || sif.rise[`EDIC_P_TRIP]) begin
			exc_on <= 1'b0;
		end else if (sif.rise[`EDIC_P_EXC_ON] && !trip_latched) begin
			exc_on <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Stopping sequence
	edic_pkg::edic_trip_st_t trip_st_ff;
	logic [`EDIC_MS_W-1:0]   stop_cnt_ff;
	logic                    stop_done;

	assign stop_done = (trip_st_ff == edic_pkg::TRIP_RETARD) && (stop_cnt_ff >= stop_dly_ff);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			trip_st_ff <= edic_pkg::TRIP_IDLE;
		end else begin
			case (trip_st_ff)
				edic_pkg::TRIP_IDLE: begin
					if (sif.rise[`EDIC_P_TRIP]) begin
						trip_st_ff <= edic_pkg::TRIP_RETARD;
					end
				end
				edic_pkg::TRIP_RETARD: begin
					if (stop_done) begin
						trip_st_ff <= edic_pkg::TRIP_OPEN;
					end
				end
				edic_pkg::TRIP_OPEN: begin
					if (!sif.lvl[`EDIC_P_FB_CLOSED]) begin
						trip_st_ff <= edic_pkg::TRIP_IDLE;
					end
				end
				default: trip_st_ff <= edic_pkg::TRIP_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst || (trip_st_ff != edic_pkg::TRIP_RETARD)) begin
			stop_cnt_ff <= '0;
		end else if (ms_tick && !stop_done) begin
			stop_cnt_ff <= stop_cnt_ff + `EDIC_MS_W'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			phase_retard <= 1'b0;
		end else begin
			phase_retard <= (trip_st_ff == edic_pkg::TRIP_RETARD) && !stop_done;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Field breaker orders
	logic open_req;
	logic close_req;

	assign open_req  = stop_done || (di_ok && sif.rise[`EDIC_P_FB_OPEN]);
	// close command
	// A trip edge in the same cycle refuses the close before the latch shows it
	assign close_req = di_ok && sif.rise[`EDIC_P_FB_CLOSE] && !trip_latched &&
		!sif.rise[`EDIC_P_TRIP] && (trip_st_ff == edic_pkg::TRIP_IDLE);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			fb_open_order <= 1'b0;
		end else if (open_req) begin
			fb_open_order <= 1'b1;
		end else if (close_req || !sif.lvl[`EDIC_P_FB_CLOSED]) begin
			fb_open_order <= 1'b0;
		end
	end

	// Open beats close; close stands until feedback shows the breaker in
	always_ff @(posedge core_clk) begin
		if (rst) begin
			fb_close_order <= 1'b0;
		end else if (open_req || sif.lvl[`EDIC_P_FB_CLOSED]) begin
			fb_close_order <= 1'b0;
		end else if (close_req) begin
			fb_close_order <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			fb_is_closed <= 1'b0;
		end else begin
			fb_is_closed <= sif.lvl[`EDIC_P_FB_CLOSED];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Reactive power unloading
	logic [`EDIC_MS_W-1:0] unl_cnt_ff;
	logic                  unl_start;
	logic                  unl_end;

	assign unl_start = di_ok && sif.rise[`EDIC_P_UNLOAD];
	assign unl_end   = unloading && (unl_cnt_ff >= unload_to_ff);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			unloading <= 1'b0;
		end else if (unl_start) begin
			unloading <= 1'b1;
		end else if (unl_end) begin
			unloading <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst || unl_start || !unloading) begin
			unl_cnt_ff <= '0;
		end else if (ms_tick && !unl_end) begin
			unl_cnt_ff <= unl_cnt_ff + `EDIC_MS_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register read
	logic [`EDIC_DATA_W-1:0] status;
	logic [`EDIC_DATA_W-1:0] rd_mux;

	always_comb begin
		status = '0;
		status[`EDIC_F_ST_MODE_HI:`EDIC_F_ST_MODE_LO] = mode_ff;
		status[`EDIC_F_ST_EXC]      = exc_on;
		status[`EDIC_F_ST_TRIP]     = trip_latched;
		status[`EDIC_F_ST_REMOTE]   = remote_active;
		status[`EDIC_F_ST_RETARD]   = phase_retard;
		status[`EDIC_F_ST_FB_OPEN]  = fb_open_order;
		status[`EDIC_F_ST_FB_CLOSE] = fb_close_order;
		status[`EDIC_F_ST_UNLOAD]   = unloading;
		status[`EDIC_F_ST_FB_IN]    = fb_is_closed;
		status[`EDIC_F_ST_OVR]      = sif.lvl[`EDIC_P_OVR];
	end

	always_comb begin
		case (reg_addr)
			`EDIC_A_CTRL:      rd_mux = `EDIC_DATA_W'(ctrl_ff);
			`EDIC_A_STOP_DLY:  rd_mux = `EDIC_DATA_W'(stop_dly_ff);
			`EDIC_A_UNLOAD_TO: rd_mux = `EDIC_DATA_W'(unload_to_ff);
			`EDIC_A_RAMP:      rd_mux = `EDIC_DATA_W'(ramp_ff);
			`EDIC_A_STATUS:    rd_mux = status;
			`EDIC_A_ACT_REF:   rd_mux = `EDIC_DATA_W'(active_ref);
			`EDIC_A_TEST_REF:  rd_mux = `EDIC_DATA_W'(test_ref);
			default:           rd_mux = '0;
		endcase
	end

	// Data stand only in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (rst || !reg_rd) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= rd_mux;
		end
	end
endmodule : edic_top
`default_nettype wire
